// ---- hw/c2gc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module c2gc_regs
    import c2gc_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Register port from the control interface
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Gain controller mode, bit 3 of register 108
    input wire logic AGC_MODE_BIT,
    // Raw register contents
    output logic [7:0] INPUT_CONFIG,
    output logic [7:0] GAIN_CONFIG,
    output logic CFG_UPDATED,
    // Decoded front-end controls
    output logic LINE_INPUT,
    output logic SRC_ANALOG_DIFF,
    output logic SRC_ANALOG_SE,
    output logic SRC_PDM,
    output logic DC_COUPLED,
    output logic IMP_2K5,
    output logic IMP_10K,
    output logic IMP_20K,
    output logic AGC_ON,
    output logic AGC_MODE,
    output logic [6:0] GAIN_CODE,
    output logic GAIN_NEGATIVE,
    output logic CFG_FAULT
);

    typedef struct packed {
        logic [7:0] input_cfg;
        logic [7:0] gain_cfg;
        logic [7:0] rdata;
        logic rvalid;
        logic updated;
    } c2gc_state_t;

    c2gc_state_t state_reg;
    c2gc_state_t state_next;

    // Only bits under the mask may change
    function automatic logic [7:0] merge_write(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] wmask
    );
        return (old_val & ~wmask) | (new_val & wmask);
    endfunction

    always_comb
    begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        state_next.updated = 1'b0;

        // Write path; a write and a read in one cycle are both served
        if (REG_WR)
        begin
            if (REG_ADDR == C2GC_OFF_INPUT)
            begin
                // Bit 1 is read-only zero whatever software sends
                state_next.input_cfg = merge_write(state_reg.input_cfg,
                    REG_WDATA, C2GC_INPUT_WMASK);
                state_next.updated = 1'b1;
            end
            else if (REG_ADDR == C2GC_OFF_GAIN)
            begin
                state_next.gain_cfg = merge_write(state_reg.gain_cfg,
                    REG_WDATA, C2GC_GAIN_WMASK);
                state_next.updated = 1'b1;
            end
        end

        // Read path returns the value held before any same-cycle write
        if (REG_RD)
        begin
            state_next.rvalid = 1'b1;
            if (REG_ADDR == C2GC_OFF_INPUT)
            begin
                state_next.rdata = state_reg.input_cfg
                    & C2GC_INPUT_WMASK;
            end
            else if (REG_ADDR == C2GC_OFF_GAIN)
            begin
                state_next.rdata = state_reg.gain_cfg;
            end
            else
            begin
                state_next.rdata = C2GC_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            state_reg.input_cfg <= C2GC_INPUT_RESET;
            state_reg.gain_cfg <= C2GC_GAIN_RESET;
            state_reg.rdata <= C2GC_UNMAPPED_READ;
            state_reg.rvalid <= 1'b0;
            state_reg.updated <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign INPUT_CONFIG = state_reg.input_cfg;
    assign GAIN_CONFIG = state_reg.gain_cfg;
    assign REG_RDATA = state_reg.rdata;
    assign REG_RVALID = state_reg.rvalid;
    assign CFG_UPDATED = state_reg.updated;

    // Decoded controls lag the registers by one cycle
    c2gc_decode u_decode
    (
        .clk(SYS_CLK),
        .rst(RST),
        .input_cfg(state_reg.input_cfg),
        .gain_cfg(state_reg.gain_cfg),
        .agc_mode_bit(AGC_MODE_BIT),
        .line_input(LINE_INPUT),
        .src_diff(SRC_ANALOG_DIFF),
        .src_se(SRC_ANALOG_SE),
        .src_pdm(SRC_PDM),
        .dc_coupled(DC_COUPLED),
        .imp_2k5(IMP_2K5),
        .imp_10k(IMP_10K),
        .imp_20k(IMP_20K),
        .agc_on(AGC_ON),
        .agc_mode(AGC_MODE),
        .gain_code(GAIN_CODE),
        .gain_negative(GAIN_NEGATIVE),
        .cfg_fault(CFG_FAULT)
    );

endmodule
`default_nettype wire

// ---- pkg/c2gc_pkg.sv ----
// What this block does
// - Input register bit 7 picks the input kind: 0 microphone, 1 line.
// - Bits 6-5 pick the source: 0 diff, 1 single-ended, 2 PDM, 3 reserved.
// - Bit 4 picks AC (0) or DC (1) coupling, for an analog source only.
// - Bits 3-2 set impedance: 0 2.5 kohm, 1 10 kohm, 2 20 kohm, 3 reserved.
// - Bit 0 enables gain control, run as bit 3 of register 108 says.
// - Gain bits 7-1 set 0.5 dB steps from 0 dB, code 84 giving 42 dB.
// - Gain bit 0 makes gain negative, to -11 dB, and raises CFG_FAULT at the 2.5 kohm setting.
// - The gain register at 0x42 resets to zero, meaning 0 dB positive gain.
// - Input register 0x41 resets to zero: mic, diff, AC, 2.5 kohm, no AUTOMATIC_GAIN_CONTROLLER.
`default_nettype none
package c2gc_pkg;

    // Register map
    localparam logic [7:0] C2GC_OFF_INPUT = 8'h41;
    localparam logic [7:0] C2GC_OFF_GAIN = 8'h42;
    localparam logic [7:0] C2GC_INPUT_RESET = 8'h00;
    localparam logic [7:0] C2GC_GAIN_RESET = 8'h00;
    localparam logic [7:0] C2GC_INPUT_WMASK = 8'hFD;
    localparam logic [7:0] C2GC_GAIN_WMASK = 8'hFF;
    localparam logic [7:0] C2GC_UNMAPPED_READ = 8'h00;

    // Input register fields
    localparam int C2GC_KIND_BIT = 7;
    localparam int C2GC_SRC_HI = 6;
    localparam int C2GC_SRC_LO = 5;
    localparam int C2GC_DC_BIT = 4;
    localparam int C2GC_IMP_HI = 3;
    localparam int C2GC_IMP_LO = 2;
    localparam int C2GC_RSVD_BIT = 1;
    localparam int C2GC_AGC_BIT = 0;

    // Gain register fields
    localparam int C2GC_GAIN_HI = 7;
    localparam int C2GC_GAIN_LO = 1;
    localparam int C2GC_SIGN_BIT = 0;

    // Field codes
    localparam logic [1:0] C2GC_SRC_DIFF = 2'h0;
    localparam logic [1:0] C2GC_SRC_SE = 2'h1;
    localparam logic [1:0] C2GC_SRC_PDM = 2'h2;
    localparam logic [1:0] C2GC_IMP_2K5 = 2'h0;
    localparam logic [1:0] C2GC_IMP_10K = 2'h1;
    localparam logic [1:0] C2GC_IMP_20K = 2'h2;
    localparam logic [6:0] C2GC_GAIN_MAX = 7'h54;
    localparam logic [6:0] C2GC_NEG_GAIN_MAX = 7'h16;

    // Saturate a gain code at a ceiling
    function automatic logic [6:0] c2gc_clamp(
        input logic [6:0] code,
        input logic [6:0] ceiling
    );
        logic [6:0] res;
        res = code;
        if (code > ceiling)
        begin
            res = ceiling;
        end
        return res;
    endfunction

endpackage
`default_nettype wire

// ---- hw/c2gc_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module c2gc_decode
    import c2gc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register contents
    input wire logic [7:0] input_cfg,
    input wire logic [7:0] gain_cfg,
    input wire logic agc_mode_bit,
    // Front-end controls
    output logic line_input,
    output logic src_diff,
    output logic src_se,
    output logic src_pdm,
    output logic dc_coupled,
    output logic imp_2k5,
    output logic imp_10k,
    output logic imp_20k,
    output logic agc_on,
    output logic agc_mode,
    output logic [6:0] gain_code,
    output logic gain_negative,
    output logic cfg_fault
);

    typedef struct packed {
        logic line_input;
        logic src_diff;
        logic src_se;
        logic src_pdm;
        logic dc_coupled;
        logic imp_2k5;
        logic imp_10k;
        logic imp_20k;
        logic agc_on;
        logic agc_mode;
        logic [6:0] gain_code;
        logic gain_negative;
        logic cfg_fault;
    } c2gc_fe_t;

    c2gc_fe_t fe_reg;
    c2gc_fe_t fe_next;

    always_comb
    begin
        logic analog;
        logic [6:0] code;
        analog = 1'b0;
        code = 7'h00;
        fe_next = '0;
        fe_next.line_input = input_cfg[C2GC_KIND_BIT];
        case (input_cfg[C2GC_SRC_HI:C2GC_SRC_LO])
            C2GC_SRC_DIFF: fe_next.src_diff = 1'b1;
            C2GC_SRC_SE: fe_next.src_se = 1'b1;
            C2GC_SRC_PDM: fe_next.src_pdm = 1'b1;
            // Reserved source: leave every path off, flag it
            default: fe_next.cfg_fault = 1'b1;
        endcase
        analog = fe_next.src_diff | fe_next.src_se;
        // Coupling and load mean nothing to a PDM microphone
        fe_next.dc_coupled = analog & input_cfg[C2GC_DC_BIT];
        case (input_cfg[C2GC_IMP_HI:C2GC_IMP_LO])
            C2GC_IMP_2K5: fe_next.imp_2k5 = analog;
            C2GC_IMP_10K: fe_next.imp_10k = analog;
            C2GC_IMP_20K: fe_next.imp_20k = analog;
            default: fe_next.cfg_fault = 1'b1;
        endcase
        fe_next.agc_on = input_cfg[C2GC_AGC_BIT];
        fe_next.agc_mode = input_cfg[C2GC_AGC_BIT] & agc_mode_bit;
        code = gain_cfg[C2GC_GAIN_HI:C2GC_GAIN_LO];
        fe_next.gain_negative = gain_cfg[C2GC_SIGN_BIT];
        if (gain_cfg[C2GC_SIGN_BIT])
        begin
            // Negative range stops at -11 dB
            fe_next.gain_code = c2gc_clamp(code, C2GC_NEG_GAIN_MAX);
            if (code > C2GC_NEG_GAIN_MAX
                || input_cfg[C2GC_IMP_HI:C2GC_IMP_LO] == C2GC_IMP_2K5)
            begin
                fe_next.cfg_fault = 1'b1;
            end
        end
        else
        begin
            fe_next.gain_code = c2gc_clamp(code, C2GC_GAIN_MAX);
            if (code > C2GC_GAIN_MAX)
            begin
                fe_next.cfg_fault = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fe_reg <= '0;
        end
        else
        begin
            fe_reg <= fe_next;
        end
    end

    assign line_input = fe_reg.line_input;
    assign src_diff = fe_reg.src_diff;
    assign src_se = fe_reg.src_se;
    assign src_pdm = fe_reg.src_pdm;
    assign dc_coupled = fe_reg.dc_coupled;
    assign imp_2k5 = fe_reg.imp_2k5;
    assign imp_10k = fe_reg.imp_10k;
    assign imp_20k = fe_reg.imp_20k;
    assign agc_on = fe_reg.agc_on;
    assign agc_mode = fe_reg.agc_mode;
    assign gain_code = fe_reg.gain_code;
    assign gain_negative = fe_reg.gain_negative;
    assign cfg_fault = fe_reg.cfg_fault;

endmodule
`default_nettype wire

// ---- test/c2gc_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module c2gc_regs_monitor
    import c2gc_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    // Contents and decoded fields
    input wire logic [7:0] INPUT_CONFIG,
    input wire logic [7:0] GAIN_CONFIG,
    input wire logic LINE_INPUT,
    input wire logic SRC_PDM,
    input wire logic AGC_ON,
    input wire logic GAIN_NEGATIVE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    a_input_write: assert property (
        REG_WR && REG_ADDR == C2GC_OFF_INPUT
        |=> INPUT_CONFIG == ($past(REG_WDATA) & 8'hFD))
        else $error("input register write mismatch");
    a_gain_write: assert property (
        REG_WR && REG_ADDR == C2GC_OFF_GAIN
        |=> GAIN_CONFIG == $past(REG_WDATA))
        else $error("gain register write mismatch");
    a_reset_clear: assert property (
        $fell(RST) |-> INPUT_CONFIG == 8'h00 && GAIN_CONFIG == 8'h00)
        else $error("registers not clear after reset");
    a_rsvd_zero: assert property (INPUT_CONFIG[1] == 1'b0)
        else $error("reserved bit set");
    a_kind_follows: assert property (
        !$past(RST) |-> LINE_INPUT == $past(INPUT_CONFIG[7]))
        else $error("input kind not decoded");
    a_pdm_follows: assert property (
        !$past(RST) |-> SRC_PDM == ($past(INPUT_CONFIG[6:5]) == 2'h2))
        else $error("pdm source not decoded");
    a_agc_follows: assert property (
        !$past(RST) |-> AGC_ON == $past(INPUT_CONFIG[0]))
        else $error("auto gain enable not decoded");
    a_sign_follows: assert property (
        !$past(RST) |-> GAIN_NEGATIVE == $past(GAIN_CONFIG[0]))
        else $error("gain sign not decoded");

    c_input_write: cover property (REG_WR && REG_ADDR == C2GC_OFF_INPUT);
    c_gain_write: cover property (REG_WR && REG_ADDR == C2GC_OFF_GAIN);
    c_reset_release: cover property ($fell(RST));
endmodule
`default_nettype wire

// ---- test/c2gc_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module c2gc_regs_test
    import c2gc_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic AGC_MODE_BIT = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic [7:0] REG_RDATA, INPUT_CONFIG, GAIN_CONFIG;
    logic REG_RVALID, CFG_UPDATED, LINE_INPUT, SRC_ANALOG_DIFF;
    logic SRC_ANALOG_SE, SRC_PDM, DC_COUPLED, IMP_2K5, IMP_10K;
    logic IMP_20K, AGC_ON, AGC_MODE, GAIN_NEGATIVE, CFG_FAULT;
    logic [6:0] GAIN_CODE;
    logic [9:0] dec;
    logic [7:0] cfgs [5] = '{8'h00, 8'hB5, 8'h59, 8'h7D, 8'h88};
    logic [7:0] gains [6] = '{8'hA8, 8'hA6, 8'h2F, 8'h2B, 8'h02, 8'h2D};
    int n_fail = 0;
    int n_tests = 0;

    assign dec = {LINE_INPUT, SRC_ANALOG_DIFF, SRC_ANALOG_SE, SRC_PDM,
        DC_COUPLED, IMP_2K5, IMP_10K, IMP_20K, AGC_ON, AGC_MODE};

    c2gc_regs c2gc_regs_inst (
        .SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .AGC_MODE_BIT(AGC_MODE_BIT), .INPUT_CONFIG(INPUT_CONFIG),
        .GAIN_CONFIG(GAIN_CONFIG), .CFG_UPDATED(CFG_UPDATED),
        .LINE_INPUT(LINE_INPUT), .SRC_ANALOG_DIFF(SRC_ANALOG_DIFF),
        .SRC_ANALOG_SE(SRC_ANALOG_SE), .SRC_PDM(SRC_PDM),
        .DC_COUPLED(DC_COUPLED), .IMP_2K5(IMP_2K5), .IMP_10K(IMP_10K),
        .IMP_20K(IMP_20K), .AGC_ON(AGC_ON), .AGC_MODE(AGC_MODE),
        .GAIN_CODE(GAIN_CODE), .GAIN_NEGATIVE(GAIN_NEGATIVE),
        .CFG_FAULT(CFG_FAULT)
    );

    initial
    begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    task automatic test_done;
        if (n_fail == 0 && n_tests > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
        #1;
        chk({9'h000, CFG_UPDATED},
            {9'h000, a == C2GC_OFF_INPUT || a == C2GC_OFF_GAIN});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        chk({1'b0, REG_RVALID, REG_RDATA}, {2'b01, e});
    endtask

    // Decoded outputs trail the registers by one edge
    task automatic settle;
        @(posedge SYS_CLK);
        #1;
    endtask

    function automatic logic [9:0] dec_exp(input logic [7:0] d,
        input logic m);
        logic [1:0] s;
        logic [1:0] z;
        logic an;
        s = d[6:5];
        z = d[3:2];
        an = s < 2'h2;
        return {d[7], s == 2'h0, s == 2'h1, s == 2'h2, d[4] & an,
            an && z == 2'h0, an && z == 2'h1, an && z == 2'h2, d[0], d[0] & m};
    endfunction

    function automatic logic [9:0] gain_exp(input logic [7:0] g,
        input logic [1:0] z);
        logic [6:0] top;
        top = g[0] ? 7'h16 : 7'h54;
        return {g[0], g[7:1] > top || (g[0] && z == 2'h0), 1'b0,
            g[7:1] > top ? top : g[7:1]};
    endfunction

    initial
    begin
        repeat (8) @(posedge SYS_CLK);
        RST <= 1'b0;
        settle();
        chk(dec, dec_exp(8'h00, 1'b0));
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        rd(8'h40, 8'h00);
        wr(8'h41, 8'hFF);
        rd(8'h41, 8'hFD);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge SYS_CLK);
            AGC_MODE_BIT <= i[0];
            wr(8'h41, cfgs[i]);
            settle();
            chk(dec, dec_exp(cfgs[i], i[0]));
            chk({9'h000, CFG_FAULT}, {9'h000,
                cfgs[i][6:5] == 2'h3 || cfgs[i][3:2] == 2'h3});
        end
        wr(8'h41, 8'h04);
        for (int j = 0; j < 6; j++)
        begin
            wr(8'h42, gains[j]);
            settle();
            chk({GAIN_NEGATIVE, CFG_FAULT, 1'b0, GAIN_CODE},
                gain_exp(gains[j], 2'h1));
            rd(8'h42, gains[j]);
        end
        wr(8'h41, 8'h00);
        settle();
        chk({GAIN_NEGATIVE, CFG_FAULT, 1'b0, GAIN_CODE},
            gain_exp(8'h2D, 2'h0));
        wr(8'h43, 8'h55);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h2D);
        @(posedge SYS_CLK);
        RST <= 1'b1;
        @(posedge SYS_CLK);
        RST <= 1'b0;
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        test_done();
    end

    initial
    begin
        #100000;
        n_fail++;
        test_done();
    end
endmodule

bind c2gc_regs c2gc_regs_monitor c2gc_regs_monitor_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .INPUT_CONFIG(INPUT_CONFIG),
    .GAIN_CONFIG(GAIN_CONFIG), .LINE_INPUT(LINE_INPUT), .SRC_PDM(SRC_PDM),
    .AGC_ON(AGC_ON), .GAIN_NEGATIVE(GAIN_NEGATIVE)
);
`default_nettype wire
